/* File: verilog/mmo_defines.svh */
/*
 * Constants for the shared-memory ordering unit: widths, depth and the
 * reset value of the shared words.
 * Assumes it is included by bare name; the guard lets it be included more than once.
 */
`ifndef MMO_DEFINES_SVH
`define MMO_DEFINES_SVH

// ************************************************************
// widths and sizes
// ************************************************************
`define MMO_AW        4
`define MMO_DW        32
`define MMO_NCORE     4
`define MMO_NCORE_MIN 2
`define MMO_NCORE_MAX 8

// ************************************************************
// reset value and store answer data
// ************************************************************
`define MMO_MEM_RST   32'h0000_0000
`define MMO_ACK_DATA  32'h0000_0000

`endif

/* File: verilog/mmo_pkg.sv */
/*
 * Types shared by the ordering unit and its users: operation codes,
 * the request carrier and the per-core state record.
 * Assumes mmo_defines.svh is on the include path.
 */
`include "mmo_defines.svh"

package mmo_pkg;

   // ************************************************************
   // operation codes
   // ************************************************************
   typedef enum logic [1:0] {
      MMO_LOAD      = 2'b00,
      MMO_STORE     = 2'b01,
      MMO_LOCK_SWAP = 2'b11,
      MMO_LOCK_ADD  = 2'b10
   } mmo_op_e;

   typedef logic [`MMO_AW-1:0] mmo_addr_t;
   typedef logic [`MMO_DW-1:0] mmo_data_t;

   // ************************************************************
   // request carrier, one per core
   // ************************************************************
   typedef struct packed {
      mmo_op_e   op;
      mmo_addr_t addr;
      mmo_data_t data;
   } mmo_req_s;

   // ************************************************************
   // per-core state: pending op, store buffer, answer
   // ************************************************************
   typedef struct packed {
      logic      pend;
      mmo_op_e   op;
      mmo_addr_t addr;
      mmo_data_t data;
      logic      sb_v;
      mmo_addr_t sb_addr;
      mmo_data_t sb_data;
      logic      rsp_v;
      mmo_data_t rsp_data;
   } mmo_core_s;

endpackage

/* File: verilog/mmo_order.sv */
/*
 * Shared-memory ordering unit: several in-order cores reach one shared
 * word memory through a single serialising port, each with a one-entry
 * store buffer that forwards to its own loads only.
 * Assumes every requester is on core_clk and holds a request stable
 * until req_ready; srst is synchronous to core_clk.
 */
`timescale 1ns/1ps
`include "mmo_defines.svh"

module mmo_order #(
   parameter int NCORE = `MMO_NCORE
) (
   input  wire logic                                  core_clk,
   input  wire logic                                  srst,
   input  wire logic              [NCORE-1:0]         req_valid,
   input  wire mmo_pkg::mmo_req_s [NCORE-1:0]         req,
   output logic                   [NCORE-1:0]         req_ready,
   output logic                   [NCORE-1:0]         rsp_valid,
   output mmo_pkg::mmo_data_t     [NCORE-1:0]         rsp_data,
   output logic                   [NCORE-1:0]         sb_pending
);
   import mmo_pkg::*;

   // ************************************************************
   // sizes and elaboration check
   // ************************************************************
   localparam int DEPTH = 1 << `MMO_AW;
   localparam int RRW   = $clog2(NCORE);

   // refuse core counts that the round robin and the state record were not
   // sized for; caught at elaboration so no silent wrap of the pointer
   if (NCORE < `MMO_NCORE_MIN || NCORE > `MMO_NCORE_MAX) begin : g_bad_ncore
      $error("mmo_order: NCORE out of range");
   end

   // a pointer narrower than one bit cannot name two cores
   if (RRW < 1) begin : g_bad_rrw
      $error("mmo_order: round robin pointer too narrow");
   end

   typedef struct packed {
      mmo_core_s [NCORE-1:0]            core;
      logic      [RRW-1:0]              rr;
      logic      [DEPTH-1:0][`MMO_DW-1:0] mem;
   } mmo_state_s;

   mmo_state_s             st;
   mmo_state_s             next_st;
   logic       [NCORE-1:0] want_load;
   logic       [NCORE-1:0] want_lock;
   logic       [NCORE-1:0] want_drain;
   logic       [NCORE-1:0] load_hit;

   // ************************************************************
   // request acceptance: one op in flight per core
   // ************************************************************
   // a core waits for each answer, so program order is kept except that a load may pass its own buffered store
   always_comb begin
      for (int i = 0; i < NCORE; i++) begin
         req_ready[i] = !st.core[i].pend
                        && !(req[i].op == MMO_STORE && st.core[i].sb_v);
      end
   end

   // ************************************************************
   // next state
   // ************************************************************
   // one memory port granted round robin: every store, locked op and load that
   // misses its own buffer meets the memory at a single point, which makes one global order
   // hazards handled here:
   //  - a drain and a new store of one core never meet in one cycle, since
   //    the store is refused while the buffer is full
   //  - a forwarded load and a drain of the same core may meet; the load
   //    reads the buffer copy, the drain writes the same value to memory
   //  - a locked op waits for its own buffer to empty, so it can never
   //    overtake an older store of its core
   // trade-off: one access per cycle keeps ordering trivial at the cost of
   // bandwidth; with many busy cores a load may wait up to NCORE cycles
   always_comb begin
      int        j;
      int        gnt_idx;
      logic      gnt_v;
      mmo_data_t old_val;
      j       = 0;
      gnt_idx = 0;
      gnt_v   = 1'b0;
      old_val = '0;
      next_st = st;

      // classify what each core wants from the shared port
      for (int i = 0; i < NCORE; i++) begin
         next_st.core[i].rsp_v = 1'b0;
         load_hit[i]   = st.core[i].pend && st.core[i].op == MMO_LOAD
                         && st.core[i].sb_v
                         && st.core[i].sb_addr == st.core[i].addr;
         want_load[i]  = st.core[i].pend && st.core[i].op == MMO_LOAD
                         && !load_hit[i];
         // locked op waits until its own earlier store has drained
         want_lock[i]  = st.core[i].pend && st.core[i].op[1]
                         && !st.core[i].sb_v;
         want_drain[i] = st.core[i].sb_v;
      end

      // round-robin pick of a single winner
      for (int k = 0; k < NCORE; k++) begin
         j = int'(st.rr) + k;
         if (j >= NCORE) begin
            j = j - NCORE;
         end
         if (!gnt_v && (want_load[j] || want_lock[j] || want_drain[j])) begin
            gnt_v   = 1'b1;
            gnt_idx = j;
         end
      end

      // own-store forwarding: invisible to every other core
      for (int i = 0; i < NCORE; i++) begin
         if (load_hit[i]) begin
            next_st.core[i].rsp_v    = 1'b1;
            next_st.core[i].rsp_data = st.core[i].sb_data;
            next_st.core[i].pend     = 1'b0;
         end
      end

      // service of the granted core
      if (gnt_v) begin
         if (want_load[gnt_idx]) begin
            // a load may pass the core's buffered store to another word
            next_st.core[gnt_idx].rsp_v    = 1'b1;
            next_st.core[gnt_idx].rsp_data = st.mem[st.core[gnt_idx].addr];
            next_st.core[gnt_idx].pend     = 1'b0;
         end else if (want_lock[gnt_idx]) begin
            // read and write in the same cycle: nothing can slip between
            old_val = st.mem[st.core[gnt_idx].addr];
            if (st.core[gnt_idx].op == MMO_LOCK_SWAP) begin
               next_st.mem[st.core[gnt_idx].addr] = st.core[gnt_idx].data;
            end else begin
               next_st.mem[st.core[gnt_idx].addr] = old_val + st.core[gnt_idx].data;
            end
            // answer on the same edge as the write, so later ops cannot overtake
            next_st.core[gnt_idx].rsp_v    = 1'b1;
            next_st.core[gnt_idx].rsp_data = old_val;
            next_st.core[gnt_idx].pend     = 1'b0;
         end else begin
            // drain: the store becomes visible to all cores at once
            next_st.mem[st.core[gnt_idx].sb_addr] = st.core[gnt_idx].sb_data;
            next_st.core[gnt_idx].sb_v            = 1'b0;
         end
         if (gnt_idx + 1 >= NCORE) begin
            next_st.rr = '0;
         end else begin
            next_st.rr = RRW'(gnt_idx + 1);
         end
      end

      // take new requests; a store is acknowledged once buffered
      for (int i = 0; i < NCORE; i++) begin
         if (req_valid[i] && req_ready[i]) begin
            if (req[i].op == MMO_STORE) begin
               next_st.core[i].sb_v     = 1'b1;
               next_st.core[i].sb_addr  = req[i].addr;
               next_st.core[i].sb_data  = req[i].data;
               next_st.core[i].rsp_v    = 1'b1;
               next_st.core[i].rsp_data = `MMO_ACK_DATA;
            end else begin
               next_st.core[i].pend = 1'b1;
               next_st.core[i].op   = req[i].op;
               next_st.core[i].addr = req[i].addr;
               next_st.core[i].data = req[i].data;
            end
         end
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   // reset clears every answer and every buffer, so no core sees a stale
   // value or a store that was never acknowledged; the memory words are
   // set to their reset value in the same edge
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st     <= '0;
         st.mem <= {DEPTH{`MMO_MEM_RST}};
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs, all from flip-flops
   // ************************************************************
   // limitation: sb_pending only shows that a store is still private to its
   // core; it says nothing about which word is buffered
   always_comb begin
      for (int i = 0; i < NCORE; i++) begin
         rsp_valid[i]  = st.core[i].rsp_v;
         rsp_data[i]   = st.core[i].rsp_data;
         sb_pending[i] = st.core[i].sb_v;
      end
   end

endmodule

/* File: verification/mmo_order_assertions.sv */
/* Checker for mmo_order: answer timing and refusals seen on core 0.
   Assumes it is bound to mmo_order, one clock core_clk, reset srst. */
`timescale 1ns/1ps
// ********************
// checker
// ********************
module mmo_order_assertions import mmo_pkg::*; #(
   parameter int NCORE = 4
) (
   input wire logic                  core_clk,
   input wire logic                  srst,
   input wire logic      [NCORE-1:0] req_valid,
   input wire mmo_req_s  [NCORE-1:0] req,
   input wire logic      [NCORE-1:0] req_ready,
   input wire logic      [NCORE-1:0] rsp_valid,
   input wire mmo_data_t [NCORE-1:0] rsp_data,
   input wire logic      [NCORE-1:0] sb_pending
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // requests taken on core 0, by kind
   sequence s_st; req_valid[0] && req_ready[0] && req[0].op == MMO_STORE; endsequence
   sequence s_ld; req_valid[0] && req_ready[0] && req[0].op == MMO_LOAD; endsequence
   sequence s_lk; req_valid[0] && req_ready[0] && req[0].op[1]; endsequence
   chk_store_ack: assert property (
      s_st |=> rsp_valid[0] && rsp_data[0] == 32'h0000_0000)
      else $error("store ack missing");
   chk_store_held: assert property (
      s_st |=> sb_pending[0])
      else $error("store not buffered");
   chk_full_refuse: assert property (
      sb_pending[0] && req[0].op == MMO_STORE |-> !req_ready[0])
      else $error("store taken over full buffer");
   chk_load_answer: assert property (
      s_ld |-> ##[2:8] rsp_valid[0])
      else $error("load answer late");
   chk_load_block: assert property (
      s_ld |=> !req_ready[0] && !rsp_valid[0])
      else $error("load not pending");
   chk_lock_wait: assert property (
      s_lk |=> !rsp_valid[0])
      else $error("lock answered too soon");
   chk_drain_bound: assert property (
      $rose(sb_pending[0]) |-> ##[1:40] !sb_pending[0])
      else $error("store never drained");
   chk_data_hold: assert property (
      !rsp_valid[0] |-> $stable(rsp_data[0]))
      else $error("answer data moved");
endmodule

bind mmo_order mmo_order_assertions #(.NCORE(NCORE)) chk_u (
   .core_clk(core_clk), .srst(srst), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
   .sb_pending(sb_pending));

/* File: verification/mmo_core_model.sv */
/* Model of one other core: issues one operation at a time.
   Assumes the unit answers each taken request once on rsp_v. */
`timescale 1ns/1ps
// ********************
// core model
// ********************
module mmo_core_model import mmo_pkg::*; (
   input  wire logic      core_clk,
   input  wire logic      ready,
   input  wire logic      rsp_v,
   input  wire mmo_data_t rsp_d,
   output mmo_req_s       rq,
   output logic           valid
);
   initial begin
      valid = 1'b0;
      rq = '{MMO_LOAD, 4'h0, 32'hFFFF_FFFF};
   end
   // hold until taken; garble data on release so no stale value looks valid
   task automatic do_op(input mmo_op_e op, input mmo_addr_t a, input mmo_data_t d,
                        output mmo_data_t r);
      int n = 0;
      @(posedge core_clk);
      valid <= 1'b1;
      rq <= '{op, a, d};
      do @(posedge core_clk); while (!ready && n++ < 200);
      valid <= 1'b0;
      rq <= '{op, a, ~d};
      do @(posedge core_clk); while (!rsp_v && n++ < 400);
      r = rsp_d;
   endtask
endmodule

/* File: verification/multicore_memory_ordering_tb.sv */
/* Testbench for mmo_order with four core models.
   Assumes memory resets to zero and each scenario uses fresh words. */
`timescale 1ns/1ps
// ********************
// testbench
// ********************
module multicore_memory_ordering_tb;
   import mmo_pkg::*;
   logic                core_clk = 1'b0;
   logic                srst = 1'b1;
   wire  [3:0]          req_valid;
   wire  mmo_req_s [3:0] req;
   logic [3:0]          req_ready, rsp_valid, sb_pending;
   mmo_data_t [3:0]     rsp_data;
   mmo_data_t           r0, r1, r2, r3, rs;
   int                  num_errors = 0;
   int                  n_checks = 0;
   mmo_order #(.NCORE(4)) dut_u (.core_clk(core_clk), .srst(srst), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .sb_pending(sb_pending));
   for (genvar i = 0; i < 4; i++) begin : g
      mmo_core_model cm_u (.core_clk(core_clk), .ready(req_ready[i]), .rsp_v(rsp_valid[i]),
         .rsp_d(rsp_data[i]), .rq(req[i]), .valid(req_valid[i]));
   end
   initial forever #5 core_clk = ~core_clk;
   // route an operation to the model of core c
   task automatic op(int c, mmo_op_e o, mmo_addr_t a, mmo_data_t d, output mmo_data_t r);
      case (c)
         0: g[0].cm_u.do_op(o, a, d, r);
         1: g[1].cm_u.do_op(o, a, d, r);
         2: g[2].cm_u.do_op(o, a, d, r);
         default: g[3].cm_u.do_op(o, a, d, r);
      endcase
   endtask
   task automatic chk(mmo_data_t got, mmo_data_t exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // two stores in a row; core 0 reads its second store back, core 1 then sees both stores
   task automatic t_forward();
      op(0, MMO_STORE, 4'h1, 32'h0000_00A5, r0);
      op(0, MMO_STORE, 4'h2, 32'h0000_005A, r0);
      op(0, MMO_LOAD, 4'h2, 0, r0);
      chk(r0, 32'h0000_005A);
      op(1, MMO_LOAD, 4'h1, 0, r1);
      op(1, MMO_LOAD, 4'h2, 0, r2);
      chk(r1, 32'h0000_00A5);
      chk(r2, 32'h0000_005A);
      $display("t_forward done");
   endtask
   // two racing locked adds fall in one order; a swap then sees the sum
   task automatic t_lock();
      fork
         op(0, MMO_LOCK_ADD, 4'h3, 1, r0);
         op(1, MMO_LOCK_ADD, 4'h3, 2, r1);
      join
      chk(32'(r0 == 0 && r1 == 1 || r1 == 0 && r0 == 2), 1);
      op(2, MMO_LOCK_SWAP, 4'h3, 9, r2);
      chk(r2, 32'h0000_0003);
      $display("t_lock done");
   endtask
   // a store before a lock is visible to core 1 once the lock answers; a later store reads back on core 0
   task automatic t_fence();
      op(0, MMO_STORE, 4'h4, 32'h0000_0077, r0);
      op(0, MMO_LOCK_SWAP, 4'h5, 1, r0);
      op(1, MMO_LOAD, 4'h4, 0, r1);
      chk(r1, 32'h0000_0077);
      chk(32'(sb_pending), 0);
      op(0, MMO_STORE, 4'h6, 2, r0);
      op(0, MMO_LOAD, 4'h6, 0, r0);
      chk(r0, 32'h0000_0002);
      $display("t_fence done");
   endtask
   // two observers must not see two foreign stores in opposite orders
   task automatic t_observe();
      fork
         op(0, MMO_STORE, 4'h8, 1, rs);
         op(1, MMO_STORE, 4'h9, 1, rs);
         begin op(2, MMO_LOAD, 4'h8, 0, r0); op(2, MMO_LOAD, 4'h9, 0, r1); end
         begin op(3, MMO_LOAD, 4'h9, 0, r2); op(3, MMO_LOAD, 4'h8, 0, r3); end
      join
      chk(32'(r0 == 1 && r1 == 0 && r2 == 1 && r3 == 0), 0);
      $display("t_observe done");
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      t_forward();
      t_lock();
      t_fence();
      t_observe();
      final_report();
   end
   // watchdog well beyond the hundred or so cycles the scenarios need
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      final_report();
   end
endmodule
